// File: hw/three_phase_polarity_cutoff.sv
/*
  Three-phase waveform output stage: carrier and phase one-shot timing,
  polarity buffers and toggles, dead-time gating, forced cutoff, shared port.
  Assumes synchronous inputs, a 40 MHz clock and an AXI4-Lite master.
*/
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module three_phase_polarity_cutoff #(
  parameter int TIMER_W = 16,
  parameter int DEAD_W  = 8
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst_b,
  input  wire logic               i_ce,
  input  wire logic               i_awvalid,
  output logic                    o_awready,
  input  wire logic [7:0]         i_awaddr,
  input  wire logic               i_wvalid,
  output logic                    o_wready,
  input  wire logic [31:0]        i_wdata,
  input  wire logic [3:0]         i_wstrb,
  output logic                    o_bvalid,
  input  wire logic               i_bready,
  output logic [1:0]              o_bresp,
  input  wire logic               i_arvalid,
  output logic                    o_arready,
  input  wire logic [7:0]         i_araddr,
  output logic                    o_rvalid,
  input  wire logic               i_rready,
  output logic [31:0]             o_rdata,
  output logic [1:0]              o_rresp,
  input  wire logic               i_output_cutoff_n,
  output motor_pkg::pin_bus_type  o_pins,
  output logic                    o_carrier_irq
);
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= motor_pkg::REG_STATUS);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  motor_pkg::wr_state_type wr_state;
  logic               aw_got;
  logic               w_got;
  logic [7:0]         awaddr_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;
  logic [1:0]         bresp_q;
  logic               aw_hs;
  logic               w_hs;
  logic               wr_fire;
  logic [7:0]         wa;
  logic [31:0]        wd;
  logic [3:0]         ws;
  logic               sel_enable;
  logic               sel_mode1;
  logic               sel_saw;
  logic               shared_buf;
  logic               out_ctrl;
  logic               w_buf;
  logic               irq_odd;
  logic               u_buf;
  logic               v_buf;
  logic [5:0]         port_data;
  logic [5:0]         port_dir;
  logic [TIMER_W-1:0] carrier_reload;
  logic [TIMER_W-1:0] width_reg [3];
  logic [DEAD_W-1:0]  dead_reg;
  logic [TIMER_W-1:0] carrier_cnt;
  logic [TIMER_W-1:0] ph_cnt [3];
  logic [DEAD_W-1:0]  dt_cnt;
  logic               underflow;
  logic               uf_count_odd;
  logic [2:0]         buf_vec;
  logic [2:0]         tog;
  logic [2:0]         rise;
  logic [2:0]         fall;
  logic               dt_fire;
  logic               dt_busy;
  logic [5:0]         wave_lvl;
  logic               cut_s;
  logic               cut_prev;
  logic               cut_fall;
  logic [31:0]        read_word;
  logic [31:0]        wr_sel_word;
  logic               wr_sel;

  // Write channel: address and data accepted in either order
  assign o_awready = i_ce && (wr_state == motor_pkg::WR_COLLECT) && !aw_got;
  assign o_wready  = i_ce && (wr_state == motor_pkg::WR_COLLECT) && !w_got;
  assign aw_hs     = i_awvalid && o_awready;
  assign w_hs      = i_wvalid && o_wready;
  assign wr_fire   = i_ce && (wr_state == motor_pkg::WR_COLLECT)
                     && (aw_got || aw_hs) && (w_got || w_hs);
  assign wa        = aw_got ? awaddr_q : i_awaddr;
  assign wd        = w_got ? wdata_q : i_wdata;
  assign ws        = w_got ? wstrb_q : i_wstrb;
  assign o_bvalid  = (wr_state == motor_pkg::WR_RESP);
  assign o_bresp   = bresp_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wr_state <= motor_pkg::WR_COLLECT;
      aw_got   <= 1'b0;
      w_got    <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      bresp_q  <= motor_pkg::RESP_OKAY;
    end else if (i_ce) begin
      case (wr_state)
        motor_pkg::WR_COLLECT: begin
          if (aw_hs) begin
            aw_got   <= 1'b1;
            awaddr_q <= i_awaddr;
          end
          if (w_hs) begin
            w_got   <= 1'b1;
            wdata_q <= i_wdata;
            wstrb_q <= i_wstrb;
          end
          if (wr_fire) begin
            wr_state <= motor_pkg::WR_RESP;
            aw_got   <= 1'b0;
            w_got    <= 1'b0;
            bresp_q  <= is_mapped(wa) ? motor_pkg::RESP_OKAY : motor_pkg::RESP_SLVERR;
          end
        end
        motor_pkg::WR_RESP: begin
          if (i_bready) begin
            wr_state <= motor_pkg::WR_COLLECT;
          end
        end
        default: wr_state <= motor_pkg::WR_COLLECT;
      endcase
    end
  end

  // Read channel: one cycle from address to data
  assign o_arready = i_ce && !o_rvalid;

  always_comb begin
    read_word = 32'h0000_0000;
    case (i_araddr)
      motor_pkg::REG_SELECT: begin
        read_word[motor_pkg::SEL_ENABLE_BIT] = sel_enable;
        read_word[motor_pkg::SEL_MODE1_BIT]  = sel_mode1;
        read_word[motor_pkg::SEL_SAW_BIT]    = sel_saw;
        read_word[motor_pkg::SEL_SHARED_BIT] = shared_buf;
        read_word[motor_pkg::SEL_OUT_BIT]    = out_ctrl;
      end
      motor_pkg::REG_CTRL_W: begin
        read_word[motor_pkg::W_BUF_BIT]   = w_buf;
        read_word[motor_pkg::IRQ_ODD_BIT] = irq_odd;
      end
      motor_pkg::REG_CTRL_UV: begin
        read_word[motor_pkg::U_BUF_BIT] = u_buf;
        read_word[motor_pkg::V_BUF_BIT] = v_buf;
      end
      motor_pkg::REG_PORT_DATA: read_word[5:0] = port_data;
      motor_pkg::REG_PORT_DIR:  read_word[5:0] = port_dir;
      motor_pkg::REG_CARRIER:   read_word[TIMER_W-1:0] = carrier_reload;
      motor_pkg::REG_DEAD:      read_word[DEAD_W-1:0] = dead_reg;
      motor_pkg::REG_STATUS:    read_word[5:0] = {uf_count_odd, cut_s, dt_busy, tog};
      default: begin
        for (int i = 0; i < 3; i++) begin
          if (i_araddr == motor_pkg::REG_WIDTH0 + 8'(4 * i)) begin
            read_word[TIMER_W-1:0] = width_reg[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= motor_pkg::RESP_OKAY;
    end else if (i_ce) begin
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rdata  <= read_word;
        o_rresp  <= is_mapped(i_araddr) ? motor_pkg::RESP_OKAY : motor_pkg::RESP_SLVERR;
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // Register writes
  assign wr_sel      = wr_fire && (wa == motor_pkg::REG_SELECT);
  assign wr_sel_word = merge(32'h0000_0000, wd, ws);

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sel_enable     <= 1'b0;
      sel_mode1      <= 1'b0;
      sel_saw        <= 1'b0;
      w_buf          <= 1'b0;
      irq_odd        <= 1'b0;
      u_buf          <= 1'b0;
      v_buf          <= 1'b0;
      port_data      <= 6'h00;
      carrier_reload <= motor_pkg::CARRIER_RST[TIMER_W-1:0];
      dead_reg       <= motor_pkg::DEAD_RST[DEAD_W-1:0];
      for (int i = 0; i < 3; i++) begin
        width_reg[i] <= motor_pkg::WIDTH_RST[TIMER_W-1:0];
      end
    end else if (i_ce && wr_fire) begin
      if (wr_sel && ws[0]) begin
        sel_enable <= wd[motor_pkg::SEL_ENABLE_BIT];
        sel_mode1  <= wd[motor_pkg::SEL_MODE1_BIT];
        sel_saw    <= wd[motor_pkg::SEL_SAW_BIT];
      end
      if (wa == motor_pkg::REG_CTRL_W && ws[0]) begin
        w_buf   <= wd[motor_pkg::W_BUF_BIT];
        irq_odd <= wd[motor_pkg::IRQ_ODD_BIT];
      end
      if (wa == motor_pkg::REG_CTRL_UV && ws[0]) begin
        u_buf <= wd[motor_pkg::U_BUF_BIT];
        v_buf <= wd[motor_pkg::V_BUF_BIT];
      end
      if (wa == motor_pkg::REG_PORT_DATA && ws[0]) begin
        port_data <= wd[5:0];
      end
      if (wa == motor_pkg::REG_CARRIER) begin
        carrier_reload <= TIMER_W'(merge(32'(carrier_reload), wd, ws));
      end
      if (wa == motor_pkg::REG_DEAD) begin
        dead_reg <= DEAD_W'(merge(32'(dead_reg), wd, ws));
      end
      for (int i = 0; i < 3; i++) begin
        if (wa == motor_pkg::REG_WIDTH0 + 8'(4 * i)) begin
          width_reg[i] <= TIMER_W'(merge(32'(width_reg[i]), wd, ws));
        end
      end
    end
  end

  // Cutoff sampling; one flop of history gives the clocked falling edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cut_s    <= 1'b1;
      cut_prev <= 1'b1;
    end else if (i_ce) begin
      cut_s    <= i_output_cutoff_n;
      cut_prev <= cut_s;
    end
  end
  assign cut_fall = cut_prev && !cut_s;

  // Cutoff beats any same-cycle write, so software cannot re-arm a fault
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      out_ctrl <= 1'b0;
    end else if (i_ce) begin
      if (cut_fall || !cut_s) begin
        out_ctrl <= 1'b0;
      end else if (wr_sel && ws[0]) begin
        out_ctrl <= wd[motor_pkg::SEL_OUT_BIT];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      port_dir <= 6'h00;
    end else if (i_ce) begin
      if (cut_fall || !cut_s) begin
        port_dir <= 6'h00;
      end else if (wr_fire && wa == motor_pkg::REG_PORT_DIR && ws[0]) begin
        port_dir <= wd[5:0];
      end
    end
  end

  // Shared buffer flips after each copy; a software write takes precedence
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      shared_buf <= 1'b0;
    end else if (i_ce) begin
      if (wr_sel && ws[0]) begin
        shared_buf <= wr_sel_word[motor_pkg::SEL_SHARED_BIT];
      end else if (underflow && sel_mode1) begin
        shared_buf <= !shared_buf;
      end
    end
  end

  // Carrier period timer
  assign underflow = sel_enable && (carrier_cnt == '0);

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      carrier_cnt   <= '0;
      uf_count_odd  <= 1'b0;
      o_carrier_irq <= 1'b0;
    end else if (i_ce) begin
      if (!sel_enable || underflow) begin
        carrier_cnt <= carrier_reload;
      end else begin
        carrier_cnt <= carrier_cnt - 1'b1;
      end
      uf_count_odd  <= sel_enable && (uf_count_odd ^ underflow);
      o_carrier_irq <= underflow && (!sel_mode1 || (!uf_count_odd == irq_odd));
    end
  end

  assign buf_vec = sel_mode1 ? {3{shared_buf}} : {w_buf, v_buf, u_buf};

  // Phase width one-shots, toggles and dead-time gated outputs
  generate
    for (genvar p = 0; p < 3; p++) begin : g_phase
      assign rise[p] = underflow && (width_reg[p] != '0);
      assign fall[p] = (ph_cnt[p] == TIMER_W'(1)) && !rise[p];

      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          ph_cnt[p] <= '0;
        end else if (i_ce) begin
          if (!sel_enable) begin
            ph_cnt[p] <= '0;
          end else if (underflow) begin
            ph_cnt[p] <= width_reg[p];
          end else if (ph_cnt[p] != '0) begin
            ph_cnt[p] <= ph_cnt[p] - 1'b1;
          end
        end
      end

      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          tog[p] <= 1'b0;
        end else if (i_ce) begin
          if (underflow) begin
            tog[p] <= buf_vec[p];
          end else if (fall[p]) begin
            tog[p] <= !tog[p];
          end
        end
      end

      // Rising edges pass at once; falls wait for dead-time to expire
      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          wave_lvl[2*p]   <= 1'b0;
          wave_lvl[2*p+1] <= 1'b0;
        end else if (i_ce) begin
          wave_lvl[2*p]   <= !tog[p] || (dt_busy && wave_lvl[2*p]);
          wave_lvl[2*p+1] <= tog[p] || (dt_busy && wave_lvl[2*p+1]);
        end
      end
    end
  endgenerate

  assign dt_fire = (|fall) || (sel_saw && (underflow || (|rise)));
  assign dt_busy = (dt_cnt != '0);

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      dt_cnt <= '0;
    end else if (i_ce) begin
      if (dt_fire) begin
        dt_cnt <= dead_reg;
      end else if (dt_busy) begin
        dt_cnt <= dt_cnt - 1'b1;
      end
    end
  end

  // Pin mux: waveform in three-phase mode, plain port otherwise
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_pins <= '0;
    end else if (i_ce) begin
      if (sel_enable) begin
        o_pins.level <= wave_lvl;
        o_pins.oe    <= {motor_pkg::PORT_BITS{out_ctrl && cut_s}};
      end else begin
        o_pins.level <= port_data;
        o_pins.oe    <= port_dir & {motor_pkg::PORT_BITS{cut_s}};
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  AST_FALL_CLEARS_OUT: assert property (i_ce && cut_fall |=> !out_ctrl)
    else $error("cutoff edge did not clear output control");
  AST_LOW_BLOCKS_OUT: assert property (i_ce && !cut_s && wr_sel |=> !out_ctrl)
    else $error("output control set while cutoff low");
  AST_FALL_CLEARS_DIR: assert property (i_ce && cut_fall |=> port_dir == 6'h00)
    else $error("cutoff edge did not clear direction bits");
  AST_LOW_BLOCKS_DIR: assert property (i_ce && !cut_s |=> port_dir == 6'h00)
    else $error("direction bit set while cutoff low");
  AST_COPY_BUF: assert property (i_ce && underflow |=> tog == $past(buf_vec))
    else $error("buffers not copied at underflow");
  AST_FALL_INVERTS: assert property (i_ce && fall[0] && !underflow
                                     |=> tog[0] != $past(tog[0]))
    else $error("toggle not inverted at pulse end");
  AST_POLARITY: assert property (i_rst_b && i_ce && !dt_busy
                                 |=> wave_lvl[1:0] == {$past(tog[0]), !$past(tog[0])})
    else $error("output levels do not follow toggle");
  AST_FALL_HELD: assert property (i_ce && dt_busy && wave_lvl[0] |=> wave_lvl[0])
    else $error("output fell during dead-time");
  AST_START_PULSES: assert property (i_ce && underflow
                                     |=> ph_cnt[2] == $past(width_reg[2]))
    else $error("phase pulse not started at underflow");
  AST_DT_ON_FALL: assert property (i_ce && fall[1] && dead_reg != '0 |=> dt_busy)
    else $error("dead-time not fired at pulse end");
  AST_SHARED_INVERT: assert property (i_ce && underflow && sel_mode1 && !wr_sel
                                      |=> shared_buf != $past(shared_buf))
    else $error("shared buffer not inverted");
  AST_TRI_NO_RISE_DT: assert property (i_ce && !sel_saw && !(|fall) |=> !$rose(dt_busy))
    else $error("dead-time fired without pulse end in triangular");

  COV_CUTOFF: cover property (out_ctrl ##1 cut_fall ##1 !out_ctrl);
  COV_DEAD_HOLD: cover property (dt_busy && wave_lvl[0] && tog[0]);
  COV_MODE1_IRQ: cover property (sel_mode1 && o_carrier_irq);
endmodule

// File: hw/motor_pkg.sv
/*
  Shared constants and types for the three-phase polarity and cutoff block:
  register byte offsets, bit positions, reset values and the pin carrier.
  Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
*/
// Functional notes
// - Mode 0: separate U, V, W polarity buffer bits in two control registers.
// - Mode 1: one shared polarity buffer bit in the select register.
// - Carrier underflow copies polarity buffers into the phase toggle flip-flops.
// - End of a phase one-shot pulse inverts that phase toggle flip-flop.
// - Toggle 0 gives positive high, negative low; toggle 1 the reverse.
// - Three-phase mode turns six port pins into waveform outputs plus cutoff input.
// - Cutoff falling edge clears output control bit and floats all six pins.
// - While cutoff is low, the output control bit cannot be set.
// - Cutoff also clears port direction bits 0 to 5, making pins inputs.
// - While cutoff is low, no port direction bit can be set.
// - Triangular: dead-time fires on pulse ends; saw-tooth: on ends and starts.
// - Underflow raises carrier request and starts all three pulses together.
// - Saw-tooth also fires dead-time at the carrier underflow.
// - Each pulse end fires dead-time together with the toggle inversion.
// - Falling output edges wait for dead-time to end; rising edges pass.
// - Mode 1 inverts the shared buffer right after copying it.
// - Mode 1 select bit picks even (0) or odd (1) underflow requests.
// - Carrier underflow starts the phase pulses; no software start bit.
package motor_pkg;
  localparam logic [7:0] REG_SELECT    = 8'h00;
  localparam logic [7:0] REG_CTRL_W    = 8'h04;
  localparam logic [7:0] REG_CTRL_UV   = 8'h08;
  localparam logic [7:0] REG_PORT_DATA = 8'h0c;
  localparam logic [7:0] REG_PORT_DIR  = 8'h10;
  localparam logic [7:0] REG_CARRIER   = 8'h14;
  localparam logic [7:0] REG_WIDTH0    = 8'h18;
  localparam logic [7:0] REG_WIDTH2    = 8'h20;
  localparam logic [7:0] REG_DEAD      = 8'h24;
  localparam logic [7:0] REG_STATUS    = 8'h28;
  localparam int SEL_ENABLE_BIT = 0;
  localparam int SEL_MODE1_BIT  = 1;
  localparam int SEL_SAW_BIT    = 2;
  localparam int SEL_SHARED_BIT = 3;
  localparam int SEL_OUT_BIT    = 7;
  localparam int W_BUF_BIT      = 3;
  localparam int IRQ_ODD_BIT    = 5;
  localparam int U_BUF_BIT      = 5;
  localparam int V_BUF_BIT      = 4;
  localparam int PORT_BITS      = 6;
  localparam logic [15:0] CARRIER_RST = 16'h00ff;
  localparam logic [15:0] WIDTH_RST   = 16'h0000;
  localparam logic [7:0]  DEAD_RST    = 8'h04;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic [5:0] level;
    logic [5:0] oe;
  } pin_bus_type;
  typedef enum logic {
    WR_COLLECT = 1'b0,
    WR_RESP    = 1'b1
  } wr_state_type;
endpackage

// File: tb/inverter_stage_model.sv
/*
  Power stage stand-in: drives the active-low cutoff line and reports
  which gates it sees switched on. Assumes the bench requests a trip.
*/
`timescale 1ns/100ps
module inverter_stage_model (
  input  wire logic                   i_clk,
  input  wire logic                   i_trip,
  input  wire motor_pkg::pin_bus_type i_pins,
  output logic                        o_cutoff_n,
  output logic [5:0]                  o_driven
);
  // Pulled up, so the line idles high
  initial o_cutoff_n = 1'b1;
  always @(posedge i_clk) begin
    o_cutoff_n <= !i_trip;
  end
  // A floating gate reads as off at the stage
  assign o_driven = i_pins.level & i_pins.oe;
endmodule

// File: tb/three_phase_polarity_cutoff_test.sv
/*
  Bench for the three-phase output stage: AXI4-Lite register tasks and
  timed checks of toggles, dead-time, interrupts and forced cutoff.
  Assumes the power stage model beside the design.
*/
`timescale 1ns/100ps
module three_phase_polarity_cutoff_test;
  logic                   i_clk = 1'b0;
  logic                   i_rst_b = 1'b0;
  logic                   awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, trip = 1'b0;
  logic [7:0]             awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]            wdata = 32'h0, rd, rdata;
  logic [1:0]             resp, bresp, rresp;
  logic                   awready, wready, bvalid, arready, rvalid, irq, cut_n;
  logic [5:0]             driven;
  motor_pkg::pin_bus_type pins;
  int                     fail_count = 0, comparisons = 0, cycles = 0, gap;

  always #12.5 i_clk = ~i_clk;

  three_phase_polarity_cutoff three_phase_polarity_cutoff_inst (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf),
    .o_bvalid(bvalid), .i_bready(1'b1), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(1'b1), .o_rdata(rdata), .o_rresp(rresp),
    .i_output_cutoff_n(cut_n), .o_pins(pins), .o_carrier_irq(irq));

  inverter_stage_model inverter_stage_model_inst (
    .i_clk(i_clk), .i_trip(trip), .i_pins(pins), .o_cutoff_n(cut_n), .o_driven(driven));

  task automatic test_done;
    $display("counts: %0d compares, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Whole run needs a little over a thousand cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Ready and response are sampled before the edge's updates land
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = motor_pkg::RESP_OKAY);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge i_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    check(32'(bresp), 32'(er));
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge i_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd_reg(a, rd, resp);
    check(32'(resp), 32'(motor_pkg::RESP_OKAY));
    check(rd & m, e);
  endtask

  task automatic wait_irq;
    do @(posedge i_clk); while (!irq);
  endtask

  task automatic irq_gap(output int g);
    wait_irq();
    g = 0;
    do begin
      @(posedge i_clk);
      g++;
    end while (!irq);
  endtask

  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rchk(motor_pkg::REG_CARRIER, 32'hffff, 32'h00ff);
    rchk(motor_pkg::REG_DEAD, 32'hff, 32'h04);
    rd_reg(8'h2c, rd, resp);
    check(32'(resp), 32'(motor_pkg::RESP_SLVERR));
    check(rd, 32'h0);
    wr(8'h30, 32'h1, motor_pkg::RESP_SLVERR);
    $display("test reset done");
    wr(motor_pkg::REG_CARRIER, 32'h7f);
    wr(motor_pkg::REG_WIDTH0, 32'h10);
    wr(8'h1c, 32'h10);
    wr(motor_pkg::REG_WIDTH2, 32'h10);
    wr(motor_pkg::REG_DEAD, 32'h20);
    wr(motor_pkg::REG_CTRL_UV, 32'h20);
    wr(motor_pkg::REG_CTRL_W, 32'h08);
    wr(motor_pkg::REG_SELECT, 32'h01);
    repeat (4) @(posedge i_clk);
    check(32'(pins.oe), 32'h0);
    wr(motor_pkg::REG_SELECT, 32'h81);
    irq_gap(gap);
    check(32'(gap), 32'h80);
    rchk(motor_pkg::REG_STATUS, 32'h0f, 32'h05);
    repeat (24) @(posedge i_clk);
    check(32'(pins), {20'h0, 6'h3f, 6'h3f});
    repeat (36) @(posedge i_clk);
    check(32'(pins), {20'h0, 6'h19, 6'h3f});
    rchk(motor_pkg::REG_STATUS, 32'h07, 32'h02);
    wr(motor_pkg::REG_CTRL_UV, 32'h10);
    wr(motor_pkg::REG_CTRL_W, 32'h00);
    wr(motor_pkg::REG_SELECT, 32'h85);
    wait_irq();
    rchk(motor_pkg::REG_STATUS, 32'h0f, 32'h0a);
    $display("test mode0 done");
    wr(motor_pkg::REG_SELECT, 32'h0);
    wr(motor_pkg::REG_CTRL_W, 32'h0);
    wr(motor_pkg::REG_SELECT, 32'h8b);
    irq_gap(gap);
    check(32'(gap), 32'h100);
    rchk(motor_pkg::REG_STATUS, 32'h27, 32'h00);
    rchk(motor_pkg::REG_SELECT, 32'h08, 32'h08);
    wr(motor_pkg::REG_CTRL_W, 32'h20);
    wait_irq();
    rchk(motor_pkg::REG_STATUS, 32'h20, 32'h20);
    $display("test mode1 done");
    wr(motor_pkg::REG_PORT_DIR, 32'h3f);
    rchk(motor_pkg::REG_PORT_DIR, 32'h3f, 32'h3f);
    trip <= 1'b1;
    repeat (4) @(posedge i_clk);
    check(32'(pins.oe), 32'h0);
    check(32'(driven), 32'h0);
    rchk(motor_pkg::REG_SELECT, 32'h80, 32'h0);
    rchk(motor_pkg::REG_PORT_DIR, 32'h3f, 32'h0);
    wr(motor_pkg::REG_SELECT, 32'h81);
    rchk(motor_pkg::REG_SELECT, 32'h80, 32'h0);
    wr(motor_pkg::REG_PORT_DIR, 32'h3f);
    rchk(motor_pkg::REG_PORT_DIR, 32'h3f, 32'h0);
    trip <= 1'b0;
    repeat (4) @(posedge i_clk);
    wr(motor_pkg::REG_PORT_DATA, 32'h2a);
    wr(motor_pkg::REG_PORT_DIR, 32'h3f);
    rchk(motor_pkg::REG_PORT_DIR, 32'h3f, 32'h3f);
    wr(motor_pkg::REG_SELECT, 32'h0);
    repeat (2) @(posedge i_clk);
    check(32'(pins), {20'h0, 6'h2a, 6'h3f});
    wr(motor_pkg::REG_SELECT, 32'h81);
    rchk(motor_pkg::REG_SELECT, 32'h80, 32'h80);
    repeat (4) @(posedge i_clk);
    check(32'(pins.oe), 32'h3f);
    $display("test cutoff done");
    test_done();
  end
endmodule
